// ===== logic/lsie_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef LSIE_REGS_SVH
`define LSIE_REGS_SVH
`define LSIE_IDX_INT_MASK 6'h14
`define LSIE_IDX_EDGE_SEL 6'h16
`define LSIE_IDX_LINE_STAT 6'h17
`define LSIE_IDX_LOOP_STAT 6'h18
`define LSIE_IDX_INT_STAT 6'h19
`define LSIE_BIT_SYNC 4
`define LSIE_BIT_TXCLK 3
`define LSIE_BIT_DRIVER 2
`define LSIE_BIT_ALARM 1
`define LSIE_BIT_LOSS 0
`define LSIE_BIT_FAR_LOOP 5
`define LSIE_MASK_RST 5'h1f
`define LSIE_MASK_RSVD 3'h7
`define LSIE_EDGE_RST 5'h00
`define LSIE_STAT_RST 5'h00
`define LSIE_TXCLK_LOSS_CYCLES 32'h0000_0046
`endif

// ===== logic/lsie_pkg.sv
// shared types of the line status event block
package lsie_pkg;
    typedef logic [4:0] lsie_src_t;
    typedef logic [7:0] lsie_reg_t;
endpackage

// ===== logic/lsie_evt_if.sv
// carrier between register file and event detector
`timescale 1ns/1ps
interface lsie_evt_if;
    lsie_pkg::lsie_src_t lineFlags;
    lsie_pkg::lsie_src_t edgeSel;
    lsie_pkg::lsie_src_t events;
    modport src (output lineFlags, output edgeSel, input events);
    modport det (input lineFlags, input edgeSel, output events);
endinterface

// ===== logic/lsie_event_detect.sv
// transition detector with per-source edge selection
`timescale 1ns/1ps
`include "lsie_regs.svh"
module lsie_event_detect (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // flags, selects, events
    lsie_evt_if.det bus
);
    lsie_pkg::lsie_src_t prevFlags;
    lsie_pkg::lsie_src_t rise;
    lsie_pkg::lsie_src_t change;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prevFlags <= `LSIE_STAT_RST;
        end else if (clkEn) begin
            prevFlags <= bus.lineFlags;
        end
    end

    assign rise = bus.lineFlags & ~prevFlags;
    assign change = bus.lineFlags ^ prevFlags;
    // select 0 keeps rises only, select 1 takes any change
    assign bus.events = clkEn ? (rise | (change & bus.edgeSel)) : 5'h00;

    rise_only_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && $past(clkEn))
        |-> ((bus.events & ~bus.edgeSel & $past(bus.lineFlags) & ~bus.lineFlags) == 5'h00)
    ) else $error("falling flag raised event with rise-only select");

    any_change_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && $past(clkEn))
        |-> ((bus.events & (bus.lineFlags ^ $past(bus.lineFlags)) & bus.edgeSel)
            == ((bus.lineFlags ^ $past(bus.lineFlags)) & bus.edgeSel))
    ) else $error("flag change missed with any-change select");
endmodule // lsie_event_detect

// ===== logic/lsie_txclk_monitor.sv
// transmit clock watchdog counted on the master clock
`timescale 1ns/1ps
`include "lsie_regs.svh"
module lsie_txclk_monitor #(
    parameter int unsigned LOSS_CYCLES = `LSIE_TXCLK_LOSS_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // pin and flag
    input wire logic transmitClockIn,
    output logic txclkMissingFlag
);
    localparam int unsigned CNT_W = $clog2(LOSS_CYCLES + 2);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(LOSS_CYCLES);
    logic syncMeta;
    logic syncLevel;
    logic lastLevel;
    logic edgeSeen;
    logic [CNT_W-1:0] idleCnt;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncMeta <= 1'b0;
            syncLevel <= 1'b0;
            lastLevel <= 1'b0;
        end else if (clkEn) begin
            syncMeta <= transmitClockIn;
            syncLevel <= syncMeta;
            lastLevel <= syncLevel;
        end
    end

    assign edgeSeen = syncLevel ^ lastLevel;

    // saturates so a dead clock never wraps back to normal
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            idleCnt <= '0;
        end else if (clkEn) begin
            if (edgeSeen) begin
                idleCnt <= '0;
            end else if (idleCnt != '1) begin
                idleCnt <= idleCnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txclkMissingFlag <= 1'b0;
        end else if (clkEn) begin
            txclkMissingFlag <= !edgeSeen && (idleCnt >= LIMIT);
        end
    end

    toggle_clears_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && edgeSeen) |=> !txclkMissingFlag
    ) else $error("clock loss flag set right after a toggle");

    loss_after_idle_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && !edgeSeen && idleCnt == LIMIT) |=> txclkMissingFlag
    ) else $error("clock loss flag not set after idle limit");
endmodule // lsie_txclk_monitor

// ===== logic/lsie_top.sv
// line condition status, edge-selected events and interrupt behind apb
`timescale 1ns/1ps
`include "lsie_regs.svh"
module lsie_top #(
    parameter int unsigned LOSS_CYCLES = `LSIE_TXCLK_LOSS_CYCLES
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // line conditions from on-chip detectors
    input wire logic patternSyncIn,
    input wire logic driverShortIn,
    input wire logic alarmSignalIn,
    input wire logic signalLostIn,
    input wire logic farLoopbackIn,
    // transmit clock pin
    input wire logic transmitClockIn,
    // interrupt
    output logic irq
);
    lsie_pkg::lsie_src_t lineConditionStatus;
    lsie_pkg::lsie_src_t eventEdgeSelect;
    lsie_pkg::lsie_src_t eventMask;
    lsie_pkg::lsie_src_t intStatus;
    lsie_pkg::lsie_src_t readClear;
    lsie_pkg::lsie_src_t writeClear;
    lsie_pkg::lsie_reg_t next_rdata;
    logic farLoopbackActive;
    logic txclkMissingFlag;
    logic setupPhase;
    logic accessPhase;
    logic wrLow;
    logic hitMask;
    logic hitEdge;
    logic hitLine;
    logic hitLoop;
    logic hitInts;
    logic hitAny;

    lsie_evt_if evtBus ();

    function automatic logic regHit(input logic [7:0] addr, input logic [5:0] idx);
        regHit = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
    endfunction

    // ---- apb decode
    assign hitMask = regHit(paddr, `LSIE_IDX_INT_MASK);
    assign hitEdge = regHit(paddr, `LSIE_IDX_EDGE_SEL);
    assign hitLine = regHit(paddr, `LSIE_IDX_LINE_STAT);
    assign hitLoop = regHit(paddr, `LSIE_IDX_LOOP_STAT);
    assign hitInts = regHit(paddr, `LSIE_IDX_INT_STAT);
    assign hitAny = hitMask | hitEdge | hitLine | hitLoop | hitInts;
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrLow = clkEn && accessPhase && pwrite && pstrb[0];
    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = accessPhase && !hitAny;

    // ---- line flags, sampled once per cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lineConditionStatus <= `LSIE_STAT_RST;
            farLoopbackActive <= 1'b0;
        end else if (clkEn) begin
            lineConditionStatus[`LSIE_BIT_SYNC] <= patternSyncIn;
            lineConditionStatus[`LSIE_BIT_TXCLK] <= txclkMissingFlag;
            lineConditionStatus[`LSIE_BIT_DRIVER] <= driverShortIn;
            lineConditionStatus[`LSIE_BIT_ALARM] <= alarmSignalIn;
            lineConditionStatus[`LSIE_BIT_LOSS] <= signalLostIn;
            farLoopbackActive <= farLoopbackIn;
        end
    end

    lsie_txclk_monitor #(
        .LOSS_CYCLES(LOSS_CYCLES)
    ) txclkMon (
        .sys_clk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .transmitClockIn(transmitClockIn),
        .txclkMissingFlag(txclkMissingFlag)
    );

    // ---- control registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eventMask <= `LSIE_MASK_RST;
        end else if (wrLow && hitMask) begin
            eventMask <= pwdata[4:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eventEdgeSelect <= `LSIE_EDGE_RST;
        end else if (wrLow && hitEdge) begin
            // bit 4 sync, 3 txclk, 2 driver, 1 alarm, 0 loss
            eventEdgeSelect <= pwdata[4:0];
        end
    end

    // ---- event detection
    assign evtBus.lineFlags = lineConditionStatus;
    assign evtBus.edgeSel = eventEdgeSelect;

    lsie_event_detect evtDet (
        .sys_clk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .bus(evtBus)
    );

    // ---- interrupt status: only bits actually returned by the read are
    // cleared, so an event landing between setup and access is kept
    assign readClear = (accessPhase && !pwrite && hitInts) ? prdata[4:0] : 5'h00;
    assign writeClear = (accessPhase && pwrite && pstrb[0] && hitInts) ? pwdata[4:0] : 5'h00;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            intStatus <= `LSIE_STAT_RST;
        end else if (clkEn) begin
            // a new event wins over a clear in the same cycle
            intStatus <= (intStatus & ~(readClear | writeClear)) | evtBus.events;
        end
    end

    // mask gates the request only; status still records masked events
    assign irq = |(intStatus & ~eventMask);

    // ---- read data
    always_comb begin
        next_rdata = 8'h00;
        if (hitMask) begin
            next_rdata = {`LSIE_MASK_RSVD, eventMask};
        end else if (hitEdge) begin
            next_rdata = {3'h0, eventEdgeSelect};
        end else if (hitLine) begin
            next_rdata = {3'h0, lineConditionStatus};
        end else if (hitLoop) begin
            next_rdata = 8'h00;
            next_rdata[`LSIE_BIT_FAR_LOOP] = farLoopbackActive;
        end else if (hitInts) begin
            next_rdata = {3'h0, intStatus};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (clkEn && setupPhase && !pwrite) begin
            prdata <= {24'h00_0000, next_rdata};
        end
    end

    // ---- checks
    sequence readSetup(logic hit);
        clkEn && setupPhase && !pwrite && hit;
    endsequence

    sequence writeAccess(logic hit);
        wrLow && hit;
    endsequence

    mask_reset_a: assert property (
        @(posedge sys_clk)
        $fell(rst) |-> (eventMask == 5'h1f && !irq)
    ) else $error("mask not all set after reset");

    edge_write_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        writeAccess(hitEdge) |=> (eventEdgeSelect == $past(pwdata[4:0]))
    ) else $error("edge select write not stored");

    line_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        readSetup(hitLine) |=> (prdata == {27'h0, $past(lineConditionStatus)})
    ) else $error("line status read data wrong");

    loop_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        readSetup(hitLoop) |=> (prdata == {26'h0, $past(farLoopbackActive), 5'h00})
    ) else $error("loopback status read data wrong");

    loop_follow_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && $past(clkEn)) |-> (farLoopbackActive == $past(farLoopbackIn))
    ) else $error("loopback flag does not follow input");

    event_latch_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && evtBus.events != 5'h00)
        |=> ((intStatus & $past(evtBus.events)) == $past(evtBus.events))
    ) else $error("event not latched in interrupt status");

    read_clear_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (readSetup(hitInts) ##1 (clkEn && accessPhase && evtBus.events == 5'h00))
        |=> ((intStatus & $past(prdata[4:0])) == 5'h00)
    ) else $error("interrupt status not cleared by read");

    masked_quiet_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (eventMask == 5'h1f) |-> !irq
    ) else $error("interrupt raised with all sources masked");

    // a mask write lands on the same edge as the check, so it must be excluded here
    irq_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (irq && readClear == 5'h00 && writeClear == 5'h00 && !(wrLow && hitMask))
        |=> irq
    ) else $error("interrupt dropped without a clear");

    mask_write_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        writeAccess(hitMask) |=> (eventMask == $past(pwdata[4:0]))
    ) else $error("mask write not stored");

    mask_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        readSetup(hitMask) |=> (prdata == {24'h0, 3'b111, $past(eventMask)})
    ) else $error("mask read data wrong");

    edge_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        readSetup(hitEdge) |=> (prdata == {27'h0, $past(eventEdgeSelect)})
    ) else $error("edge select read data wrong");

    status_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        readSetup(hitInts) |=> (prdata == {27'h0, $past(intStatus)})
    ) else $error("interrupt status read data wrong");

    flags_follow_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && $past(clkEn))
        |-> (lineConditionStatus[`LSIE_BIT_SYNC] == $past(patternSyncIn)
            && lineConditionStatus[`LSIE_BIT_DRIVER] == $past(driverShortIn)
            && lineConditionStatus[`LSIE_BIT_ALARM] == $past(alarmSignalIn)
            && lineConditionStatus[`LSIE_BIT_LOSS] == $past(signalLostIn))
    ) else $error("line flags do not follow detector inputs");

    txclk_flag_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && $past(clkEn))
        |-> (lineConditionStatus[`LSIE_BIT_TXCLK] == $past(txclkMissingFlag))
    ) else $error("clock loss status bit lags wrongly");
endmodule // lsie_top

// ===== test/lsie_bench.sv
// self-checking bench for the line status event block
`timescale 1ns/1ps
`include "lsie_regs.svh"
module lsie_bench;
    localparam int LOSS = 4;
    logic sys_clk, rst, clkEn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData, rndWord;
    logic [3:0] pstrb;
    logic patternSyncIn, driverShortIn, alarmSignalIn, signalLostIn, farLoopbackIn;
    logic transmitClockIn, txRun, rdErr;
    logic [4:0] mFlags, mEdge, mMask, mStat;
    int num_errors = 0;
    int tests_run = 0;

    lsie_top #(.LOSS_CYCLES(LOSS)) dut_u (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .patternSyncIn(patternSyncIn), .driverShortIn(driverShortIn),
        .alarmSignalIn(alarmSignalIn), .signalLostIn(signalLostIn),
        .farLoopbackIn(farLoopbackIn), .transmitClockIn(transmitClockIn), .irq(irq));

    always #2.5 sys_clk = ~sys_clk;

    // transmit clock runs until a scenario stops it to provoke the loss flag
    always @(posedge sys_clk) begin
        if (txRun) begin
            transmitClockIn <= ~transmitClockIn;
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic checkReg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic checkIrq(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; leaves one idle edge behind it
    task automatic apbXfer(input logic [5:0] idx, input logic wr, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic setFlag(input int i, input logic v);
        case (i)
            `LSIE_BIT_SYNC: patternSyncIn <= v;
            `LSIE_BIT_TXCLK: txRun <= !v;
            `LSIE_BIT_DRIVER: driverShortIn <= v;
            `LSIE_BIT_ALARM: alarmSignalIn <= v;
            default: signalLostIn <= v;
        endcase
        if (mFlags[i] != v) begin
            if (v || mEdge[i]) begin
                mStat[i] = 1'b1;
            end
            mFlags[i] = v;
        end
        // long enough for the shortened clock watchdog and its synchroniser
        repeat (20) @(posedge sys_clk);
    endtask

    task automatic verifyEvents();
        apbXfer(`LSIE_IDX_LINE_STAT, 1'b0, 32'h0);
        checkReg(rdData, {27'h0, mFlags});
        checkIrq(irq, |(mStat & ~mMask));
        apbXfer(`LSIE_IDX_INT_STAT, 1'b0, 32'h0);
        checkReg(rdData, {27'h0, mStat});
        mStat = 5'h00;
        checkIrq(irq, 1'b0);
    endtask

    task automatic checkResetValues();
        apbXfer(`LSIE_IDX_INT_MASK, 1'b0, 32'h0);
        checkReg(rdData, 32'h0000_00ff);
        apbXfer(`LSIE_IDX_EDGE_SEL, 1'b0, 32'h0);
        checkReg(rdData, 32'h0000_0000);
        apbXfer(`LSIE_IDX_LINE_STAT, 1'b0, 32'h0);
        checkReg(rdData, 32'h0000_0000);
        apbXfer(`LSIE_IDX_INT_STAT, 1'b0, 32'h0);
        checkReg(rdData, 32'h0000_0000);
        checkIrq(irq, 1'b0);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        clkEn = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        {patternSyncIn, driverShortIn, alarmSignalIn, signalLostIn, farLoopbackIn} = '0;
        transmitClockIn = 1'b0;
        txRun = 1'b1;
        {mFlags, mEdge, mStat} = '0;
        mMask = 5'h1f;
        rdData = $urandom(91);
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        checkResetValues();
        $display("test reset values done");

        rndWord = $urandom;
        apbXfer(`LSIE_IDX_EDGE_SEL, 1'b1, rndWord);
        apbXfer(`LSIE_IDX_EDGE_SEL, 1'b0, 32'h0);
        checkReg(rdData, {27'h0, rndWord[4:0]});
        pstrb <= 4'h0;
        apbXfer(`LSIE_IDX_EDGE_SEL, 1'b1, ~rndWord);
        pstrb <= 4'hf;
        apbXfer(`LSIE_IDX_EDGE_SEL, 1'b0, 32'h0);
        checkReg(rdData, {27'h0, rndWord[4:0]});
        apbXfer(`LSIE_IDX_LINE_STAT, 1'b1, 32'h0000_001f);
        apbXfer(`LSIE_IDX_LINE_STAT, 1'b0, 32'h0);
        checkReg(rdData, 32'h0000_0000);
        apbXfer(6'h15, 1'b0, 32'h0);
        checkReg(rdData, 32'h0000_0000);
        checkIrq(rdErr, 1'b1);
        farLoopbackIn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apbXfer(`LSIE_IDX_LOOP_STAT, 1'b0, 32'h0);
        checkReg(rdData, 32'h0000_0020);
        farLoopbackIn <= 1'b0;
        $display("test register access done");

        for (int i = 0; i < 5; i++) begin
            for (int s = 0; s < 2; s++) begin
                mEdge = 5'(s) << i;
                mMask = 5'($urandom);
                if (s == 0) begin
                    mMask[i] = 1'b0;
                end
                apbXfer(`LSIE_IDX_EDGE_SEL, 1'b1, {27'h0, mEdge});
                apbXfer(`LSIE_IDX_INT_MASK, 1'b1, {27'h0, mMask});
                apbXfer(`LSIE_IDX_INT_MASK, 1'b0, 32'h0);
                checkReg(rdData, {24'h0, 3'b111, mMask});
                setFlag(i, 1'b1);
                verifyEvents();
                setFlag(i, 1'b0);
                verifyEvents();
            end
        end
        $display("test edge selected events done");

        apbXfer(`LSIE_IDX_INT_MASK, 1'b1, 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        mMask = 5'h1f;
        checkResetValues();
        $display("test second reset done");
        end_of_test();
    end
endmodule // lsie_bench
